// ==== core/shd_pkg.sv ====
package shd_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] ADR_MODE   = 4'h0;
  localparam logic [3:0] ADR_CTRL   = 4'h1;
  localparam logic [3:0] ADR_IEN    = 4'h2;
  localparam logic [3:0] ADR_FLAG   = 4'h3;
  localparam logic [3:0] ADR_IOCTL  = 4'h4;
  localparam logic [3:0] ADR_CNT    = 4'h5;
  localparam logic [3:0] ADR_CMP    = 4'h6;
  localparam logic [3:0] ADR_ACCEL  = 4'h7;
  localparam logic [3:0] ADR_CONST  = 4'h8;
  localparam logic [3:0] ADR_DECEL  = 4'h9;
  localparam logic [3:0] ADR_HOLD   = 4'hA;
  localparam logic [3:0] ADR_DELTA  = 4'hB;
  localparam logic [3:0] ADR_PDIR   = 4'hC;
  localparam logic [3:0] ADR_PDATA  = 4'hD;
  // Field positions.
  localparam int MODE_START = 7;
  localparam int MODE_GO    = 0;
  localparam int MODE_REV   = 1;
  localparam int CTRL_CCLR  = 7;
  localparam int IO_CAPTURE = 2;
  localparam int FLG_MATCH  = 0;
  localparam int FLG_DONE   = 1;
  // Values after reset.
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [1:0]  IEN_RST   = 2'h0;
  localparam logic [7:0]  IOCTL_RST = 8'h00;
  localparam logic [15:0] CMP_RST   = 16'hFFFF;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [7:0]  PDIR_RST  = 8'h00;
  localparam logic [12:0] PSS_RST   = 13'h0000;
  // Counter clock selections.
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV2 = 3'h1;
  localparam logic [2:0] CKS_DIV4 = 3'h2;
  localparam logic [2:0] CKS_DIV8 = 3'h3;
  // Timer control layout.
  typedef struct packed {
    logic       cclr;
    logic [2:0] cks;
    logic [3:0] rsvd;
  } shd_ctrl_t;
  typedef enum { PH_IDLE, PH_ACCEL, PH_CONST, PH_DECEL, PH_HOLD } shd_phase_t;
endpackage

// ==== core/shd_driver.sv ====
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module shd_driver (
  // Clock and reset.
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  // Register port.
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  // External counter clock pin.
  input  wire logic        EXT_CLK_IN,
  // Parallel port pins.
  output logic      [7:0]  PORT_OUT,
  output logic      [7:0]  PORT_OE_OUT,
  // Interrupt request.
  output logic             IRQ_OUT
);
  logic [7:0]  mode_q;
  shd_pkg::shd_ctrl_t ctrl_q;
  logic [1:0]  ien_q;
  logic [1:0]  flag_q;
  logic [7:0]  ioctl_q;
  logic [15:0] cnt_q;
  logic [15:0] cmp_q;
  logic [15:0] accel_q;
  logic [15:0] const_q;
  logic [15:0] decel_q;
  logic [15:0] hold_q;
  logic [15:0] delta_q;
  logic [7:0]  pdir_q;
  logic [7:0]  pdata_q;
  logic [12:0] pss_q;
  logic [2:0]  ext_sync_q;
  logic [2:0]  idx_q;
  logic [15:0] rem_q;
  logic        rev_q;
  shd_pkg::shd_phase_t phase_q;
  logic        tick;
  logic        match;
  logic        step;
  logic        last;
  logic        done;
  logic        wr_cnt;
  logic        wr_cmp;
  logic        go;
  logic [3:0]  pattern;

  // Decoded strobes for registers that hardware also updates.
  assign wr_cnt = WR_IN && (ADDR_IN == shd_pkg::ADR_CNT);
  assign wr_cmp = WR_IN && (ADDR_IN == shd_pkg::ADR_CMP);
  assign go     = WR_IN && (ADDR_IN == shd_pkg::ADR_MODE) &&
                  WDATA_IN[shd_pkg::MODE_GO];

  // Plain software registers; go is a self-clearing command bit.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mode_q  <= shd_pkg::MODE_RST;
      ctrl_q  <= shd_pkg::CTRL_RST;
      ien_q   <= shd_pkg::IEN_RST;
      ioctl_q <= shd_pkg::IOCTL_RST;
      accel_q <= 16'h0000;
      const_q <= 16'h0000;
      decel_q <= 16'h0000;
      hold_q  <= 16'h0000;
      delta_q <= 16'h0000;
      pdir_q  <= shd_pkg::PDIR_RST;
      pdata_q <= 8'h00;
    end else if (WR_IN) begin
      case (ADDR_IN)
        shd_pkg::ADR_MODE:  mode_q  <= {WDATA_IN[7:1], 1'b0};
        shd_pkg::ADR_CTRL:  ctrl_q  <= {WDATA_IN[7:4], 4'h0};
        shd_pkg::ADR_IEN:   ien_q   <= WDATA_IN[1:0];
        shd_pkg::ADR_IOCTL: ioctl_q <= WDATA_IN[7:0];
        shd_pkg::ADR_ACCEL: accel_q <= WDATA_IN;
        shd_pkg::ADR_CONST: const_q <= WDATA_IN;
        shd_pkg::ADR_DECEL: decel_q <= WDATA_IN;
        shd_pkg::ADR_HOLD:  hold_q  <= WDATA_IN;
        shd_pkg::ADR_DELTA: delta_q <= WDATA_IN;
        shd_pkg::ADR_PDIR:  pdir_q  <= WDATA_IN[7:0];
        shd_pkg::ADR_PDATA: pdata_q <= WDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pss_q <= shd_pkg::PSS_RST;
    end else begin
      pss_q <= pss_q + 13'h0001;
    end
  end

  // The external clock is synchronised; only the later stages feed the
  // edge detector, so the first stage never reaches logic directly.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], EXT_CLK_IN};
    end
  end

  always_comb begin
    case (ctrl_q.cks)
      shd_pkg::CKS_DIV1: tick = 1'b1;
      shd_pkg::CKS_DIV2: tick = pss_q[0];
      shd_pkg::CKS_DIV4: tick = &pss_q[1:0];
      shd_pkg::CKS_DIV8: tick = &pss_q[2:0];
      default:           tick = ext_sync_q[1] && !ext_sync_q[2];
    endcase
  end

  // Equality taken on the counter tick, so a period is cmp+1 ticks.
  assign match = tick && mode_q[shd_pkg::MODE_START] && (cnt_q == cmp_q);

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cnt_q <= shd_pkg::CNT_RST;
    end else if (wr_cnt) begin
      cnt_q <= WDATA_IN;
    end else if (match && ctrl_q.cclr) begin
      cnt_q <= 16'h0000;
    end else if (tick && mode_q[shd_pkg::MODE_START]) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Sticky flags; a set in the clearing read's cycle survives.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      flag_q <= 2'h0;
    end else begin
      if (match) begin
        flag_q[shd_pkg::FLG_MATCH] <= 1'b1;
      end else if (RD_IN && (ADDR_IN == shd_pkg::ADR_FLAG)) begin
        flag_q[shd_pkg::FLG_MATCH] <= 1'b0;
      end
      if (done) begin
        flag_q[shd_pkg::FLG_DONE] <= 1'b1;
      end else if (RD_IN && (ADDR_IN == shd_pkg::ADR_FLAG)) begin
        flag_q[shd_pkg::FLG_DONE] <= 1'b0;
      end
    end
  end

  assign IRQ_OUT = |(flag_q & ien_q);

  // Steps follow compare matches only in output-compare mode.
  assign step = match && !ioctl_q[shd_pkg::IO_CAPTURE];
  assign last = (rem_q <= 16'h0001);
  assign done = step && (phase_q == shd_pkg::PH_HOLD) && last;

  // Profile sequencer: accelerate, cruise, decelerate, hold, idle.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      phase_q <= shd_pkg::PH_IDLE;
      rem_q   <= 16'h0000;
      rev_q   <= 1'b0;
    end else if (go) begin
      phase_q <= shd_pkg::PH_ACCEL;
      rem_q   <= accel_q;
      rev_q   <= WDATA_IN[shd_pkg::MODE_REV];
    end else if (step) begin
      case (phase_q)
        shd_pkg::PH_ACCEL: begin
          phase_q <= last ? shd_pkg::PH_CONST : shd_pkg::PH_ACCEL;
          rem_q   <= last ? const_q : rem_q - 16'h0001;
        end
        shd_pkg::PH_CONST: begin
          phase_q <= last ? shd_pkg::PH_DECEL : shd_pkg::PH_CONST;
          rem_q   <= last ? decel_q : rem_q - 16'h0001;
        end
        shd_pkg::PH_DECEL: begin
          phase_q <= last ? shd_pkg::PH_HOLD : shd_pkg::PH_DECEL;
          rem_q   <= last ? hold_q : rem_q - 16'h0001;
        end
        shd_pkg::PH_HOLD: begin
          phase_q <= last ? shd_pkg::PH_IDLE : shd_pkg::PH_HOLD;
          rem_q   <= last ? 16'h0000 : rem_q - 16'h0001;
        end
        default: ;
      endcase
    end
  end

  // Compare register: software writes win; the profile retunes the period
  // once per accelerate or decelerate step, and saturates rather than wrapping to a wrong speed.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cmp_q <= shd_pkg::CMP_RST;
    end else if (wr_cmp) begin
      cmp_q <= WDATA_IN;
    end else if (step && (phase_q == shd_pkg::PH_ACCEL)) begin
      cmp_q <= (cmp_q > delta_q) ? cmp_q - delta_q : 16'h0001;
    end else if (step && (phase_q == shd_pkg::PH_DECEL)) begin
      cmp_q <= (16'hFFFF - cmp_q > delta_q) ? cmp_q + delta_q : 16'hFFFF;
    end
  end

  // Pattern index moves one way per step in accelerate, cruise and decelerate, both runs.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      idx_q <= 3'h0;
    end else if (step && (phase_q == shd_pkg::PH_ACCEL ||
                          phase_q == shd_pkg::PH_CONST ||
                          phase_q == shd_pkg::PH_DECEL)) begin
      idx_q <= rev_q ? idx_q - 3'h1 : idx_q + 3'h1;
    end
  end

  // Half-step table, bit order A, B, notA, notB.
  always_comb begin
    case (idx_q)
      3'h0:    pattern = 4'h1;
      3'h1:    pattern = 4'h3;
      3'h2:    pattern = 4'h2;
      3'h3:    pattern = 4'h6;
      3'h4:    pattern = 4'h4;
      3'h5:    pattern = 4'hC;
      3'h6:    pattern = 4'h8;
      default: pattern = 4'h9;
    endcase
  end

  // Pattern drives the low port nibble, high bits are data.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PORT_OUT <= 8'h00;
    end else begin
      PORT_OUT <= {pdata_q[7:4], pattern};
    end
  end
  assign PORT_OE_OUT = pdir_q;

  // Read data stands in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      case (ADDR_IN)
        shd_pkg::ADR_MODE:  RDATA_OUT <= {8'h00, mode_q};
        shd_pkg::ADR_CTRL:  RDATA_OUT <= {8'h00, ctrl_q};
        shd_pkg::ADR_IEN:   RDATA_OUT <= {14'h0000, ien_q};
        shd_pkg::ADR_FLAG:  RDATA_OUT <= {14'h0000, flag_q};
        shd_pkg::ADR_IOCTL: RDATA_OUT <= {8'h00, ioctl_q};
        shd_pkg::ADR_CNT:   RDATA_OUT <= cnt_q;
        shd_pkg::ADR_CMP:   RDATA_OUT <= cmp_q;
        shd_pkg::ADR_ACCEL: RDATA_OUT <= accel_q;
        shd_pkg::ADR_CONST: RDATA_OUT <= const_q;
        shd_pkg::ADR_DECEL: RDATA_OUT <= decel_q;
        shd_pkg::ADR_HOLD:  RDATA_OUT <= hold_q;
        shd_pkg::ADR_DELTA: RDATA_OUT <= delta_q;
        shd_pkg::ADR_PDIR:  RDATA_OUT <= {8'h00, pdir_q};
        shd_pkg::ADR_PDATA: RDATA_OUT <= {8'h00, PORT_OUT};
        default:            RDATA_OUT <= 16'h0000;
      endcase
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // Checks on the behaviour above.
  match_sets_flag_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN) match |=> flag_q[shd_pkg::FLG_MATCH])
    else $error("Compare match did not set the flag.");

  flag_holds_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    flag_q[0] && !(RD_IN && ADDR_IN == shd_pkg::ADR_FLAG) |=> flag_q[0])
    else $error("Match flag dropped without a clearing read.");

  irq_gating_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    flag_q[0] && ien_q[0] |-> IRQ_OUT)
    else $error("Enabled match flag gave no interrupt.");

  stop_freezes_cnt_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    !mode_q[shd_pkg::MODE_START] && !wr_cnt |=> $stable(cnt_q))
    else $error("Counter moved while stopped.");

  forward_step_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    step && !rev_q && !go && phase_q == shd_pkg::PH_CONST
    |=> idx_q == $past(idx_q) + 3'h1)
    else $error("Forward step did not advance the pattern.");

  reverse_step_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    step && rev_q && !go && phase_q == shd_pkg::PH_CONST
    |=> idx_q == $past(idx_q) - 3'h1)
    else $error("Reverse step did not move back one pattern.");

  hold_keeps_pattern_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    phase_q == shd_pkg::PH_HOLD && !go |=> ##1 $stable(PORT_OUT[3:0]))
    else $error("Pattern changed during hold.");

  accel_shortens_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    step && phase_q == shd_pkg::PH_ACCEL && !wr_cmp && !go
    && cmp_q > delta_q |=> cmp_q == $past(cmp_q) - $past(delta_q))
    else $error("Acceleration did not shorten the period.");

  const_keeps_period_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    phase_q == shd_pkg::PH_CONST && !wr_cmp |=> $stable(cmp_q))
    else $error("Period changed while cruising.");

  port_follows_a: assert property (@(posedge CLOCK_IN)
    disable iff (!RST_B_IN)
    step |-> ##2 PORT_OUT[3:0] == pattern)
    else $error("Port did not present the pattern.");
endmodule
`default_nettype wire

// ==== dv/shd_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Drive stage and rotor of a two-phase motor, seen as half-step positions.
module shd_motor_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Phase lines and their enables from the port.
  input  wire logic [3:0] drive_in,
  input  wire logic [3:0] oe_in
);
  localparam logic [31:0] RING = 32'h98C46231;
  logic [3:0] pat_q[$];
  int         t_q[$];
  int         cyc = 0;
  int         bad = 0;
  logic [3:0] last = 4'h0;

  // Position of a pattern on the half-step ring, or -1 if it is none.
  function automatic int ring_pos(input logic [3:0] p);
    ring_pos = -1;
    for (int i = 0; i < 8; i++) begin
      if (RING[4*i+:4] == p) ring_pos = i;
    end
  endfunction

  // energized phases.
  // A winding only pulls when its line is driven and high; a jump of more
  // than one half step would make a real rotor lose position.
  always @(posedge clk_in) begin
    cyc++;
    if (rst_b_in && (drive_in & oe_in) != last && ring_pos(last) >= 0 &&
        ring_pos(drive_in & oe_in) >= 0) begin
      pat_q.push_back(drive_in & oe_in);
      t_q.push_back(cyc);
      if (((ring_pos(drive_in & oe_in) - ring_pos(last) + 8) % 8) inside
          {1, 7}) begin
      end else begin
        bad++;
      end
    end
    last <= drive_in & oe_in;
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", nm, e, g); n_fail++; end end
module tb;
  localparam logic [31:0] RING = 32'h98C46231;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        ext = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [7:0]  port;
  logic [7:0]  port_oe;
  logic        irq;
  logic [15:0] d;
  int          n_fail = 0;
  int          comparisons = 0;
  int          seed = 32'ha7ff5318;
  int          idx = 0;
  int          ecnt = 0;

  shd_driver DUT (.CLOCK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .EXT_CLK_IN(ext), .PORT_OUT(port), .PORT_OE_OUT(port_oe),
    .IRQ_OUT(irq));
  shd_motor_model motor (.clk_in(clk), .rst_b_in(rst_b),
    .drive_in(port[3:0]), .oe_in(port_oe[3:0]));

  // Clock of 100 MHz.
  initial forever #5 clk = ~clk;
  // External counter clock with a period of six system clocks.
  always @(posedge clk) begin
    ecnt <= (ecnt == 2) ? 0 : ecnt + 1;
    if (ecnt == 2) ext <= ~ext;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  // Read data are valid only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One full profile of two steps per moving leg and one hold step, then the flag and mask checks.
  task automatic run(input logic [2:0] cks, input int div, input logic rev);
    int c;
    int c0;
    int k;
    c0 = 8 + ($random(seed) & 15);
    wr(shd_pkg::ADR_CNT, 16'h0000);
    wr(shd_pkg::ADR_CMP, c0[15:0]);
    wr(shd_pkg::ADR_CTRL, {8'h00, 1'b1, cks, 4'h0});
    wr(shd_pkg::ADR_IEN, 16'h0002);
    wr(shd_pkg::ADR_MODE, rev ? 16'h0083 : 16'h0081);
    // Poll a little after the edge so the level is settled.
    for (k = 0; k < 20000 && irq !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("done irq", 1'b1, irq)
    wr(shd_pkg::ADR_MODE, 16'h0000);
    `CHK("steps", 6, motor.pat_q.size())
    c = c0;
    for (k = 0; k < 6; k++) begin
      idx = rev ? (idx + 7) % 8 : (idx + 1) % 8;
      if (motor.pat_q.size() > k)
        `CHK("pattern", RING[4*idx+:4], motor.pat_q[k])
      c = (k < 2) ? c - 1 : ((k >= 4) ? c + 1 : c);
      if (k < 5 && motor.t_q.size() > k + 1)
        `CHK("period", (c + 1) * div, motor.t_q[k+1] - motor.t_q[k])
    end
    `CHK("held", RING[4*idx+:4], port[3:0])
    wr(shd_pkg::ADR_IEN, 16'h0000);
    `CHK("masked irq", 1'b0, irq)
    wr(shd_pkg::ADR_IEN, 16'h0001);
    `CHK("match irq", 1'b1, irq)
    rd(shd_pkg::ADR_FLAG, d);
    `CHK("flags", 16'h0003, d)
    `CHK("cleared irq", 1'b0, irq)
    motor.pat_q.delete();
    motor.t_q.delete();
    $display("test profile clock %0d reverse %0d ended", cks, rev);
  endtask

  // Watchdog against a hang.
  initial begin
    #(10 * 80000);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(shd_pkg::ADR_CMP, d);
    `CHK("cmp reset", 16'hFFFF, d)
    `CHK("pattern A", 4'h1, port[3:0])
    rd(4'hE, d);
    `CHK("unmapped", 16'h0000, d)
    wr(shd_pkg::ADR_CTRL, 16'h00FF);
    rd(shd_pkg::ADR_CTRL, d);
    `CHK("ctrl", 16'h00F0, d)
    wr(shd_pkg::ADR_IOCTL, 16'h0004);
    rd(shd_pkg::ADR_IOCTL, d);
    `CHK("ioctl", 16'h0004, d)
    wr(shd_pkg::ADR_IOCTL, 16'h0000);
    wr(shd_pkg::ADR_CNT, 16'h1234);
    repeat (5) @(posedge clk);
    rd(shd_pkg::ADR_CNT, d);
    `CHK("stopped count", 16'h1234, d)
    wr(shd_pkg::ADR_PDIR, 16'h000F);
    `CHK("oe", 8'h0F, port_oe)
    d = 16'($random(seed));
    wr(shd_pkg::ADR_PDATA, d);
    @(posedge clk);
    #1 `CHK("port high", d[7:4], port[7:4])
    wr(shd_pkg::ADR_ACCEL, 16'h0002);
    wr(shd_pkg::ADR_CONST, 16'h0002);
    wr(shd_pkg::ADR_DECEL, 16'h0002);
    wr(shd_pkg::ADR_HOLD, 16'h0001);
    wr(shd_pkg::ADR_DELTA, 16'h0001);
    $display("test registers ended");
    run(shd_pkg::CKS_DIV1, 1, 1'b0);
    run(shd_pkg::CKS_DIV2, 2, 1'b1);
    run(shd_pkg::CKS_DIV4, 4, 1'b1);
    run(shd_pkg::CKS_DIV8, 8, 1'b0);
    run(3'h4, 6, 1'b0);
    // Capture mode and no clear on match: the flag sets, nothing steps.
    wr(shd_pkg::ADR_IOCTL, 16'h0004);
    wr(shd_pkg::ADR_CNT, 16'h0000);
    wr(shd_pkg::ADR_CMP, 16'h0005);
    wr(shd_pkg::ADR_CTRL, 16'h0000);
    wr(shd_pkg::ADR_MODE, 16'h0081);
    repeat (10) @(posedge clk);
    wr(shd_pkg::ADR_MODE, 16'h0000);
    `CHK("capture hold", RING[4*idx+:4], port[3:0])
    `CHK("flag irq", 1'b1, irq)
    rd(shd_pkg::ADR_CNT, d);
    `CHK("no clear", 16'h000C, d)
    rd(shd_pkg::ADR_FLAG, d);
    `CHK("capture flag", 16'h0001, d)
    $display("test capture ended");
    `CHK("half steps", 0, motor.bad)
    end_of_test();
  end
endmodule
`default_nettype wire
